// file: hdl/med_pkg.sv
package med_pkg;
  localparam logic [7:0]  CMD_ACCEL_WRITE  = 8'h43;
  localparam logic [7:0]  CMD_POS_REL      = 8'h60;
  localparam logic [7:0]  CMD_POS_RAW      = 8'h61;
  localparam logic [7:0]  IDX_POS_ACCEL    = 8'h00;
  localparam logic [7:0]  IDX_POS_DECEL    = 8'h01;
  localparam logic [7:0]  IDX_SPD_ACCEL    = 8'h02;
  localparam logic [7:0]  IDX_SPD_DECEL    = 8'h03;
  localparam logic [10:0] CAN_REQ_ID       = 11'h141;
  localparam logic [10:0] CAN_REPLY_ID     = 11'h241;
  localparam logic [7:0]  RS485_HEADER     = 8'h3e;
  localparam logic [7:0]  RS485_LENGTH     = 8'h08;
  localparam logic [31:0] ACCEL_RESET      = 32'h0000_0000;

  typedef logic [7:0] med_byte_t;
  typedef struct packed {
    med_byte_t [7:0] data;
  } med_frame_t;
  typedef struct packed {
    logic        is_rs485;
    logic [10:0] can_id;
    logic [7:0]  node_id;
  } med_addr_t;
  typedef struct packed {
    logic        wr;
    logic [1:0]  sel;
    logic [31:0] value;
  } med_nv_req_t;

  function automatic logic [31:0] med_le32(input med_frame_t f);
    return {f.data[7], f.data[6], f.data[5], f.data[4]};
  endfunction
endpackage

// file: hdl/med_addr_check.sv
module med_addr_check (
  // frame address
  input  wire med_pkg::med_addr_t addr,
  input  wire logic [7:0]         my_node_id,
  // result
  output logic                    match
);
  import med_pkg::*;

  always_comb begin
    if (addr.is_rs485) begin
      match = (addr.node_id == my_node_id);
    end else begin
      match = (addr.can_id == CAN_REQ_ID);
    end
  end
endmodule

// file: hdl/med_accel_store.sv
module med_accel_store (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst,
  // update request
  input  wire med_pkg::med_nv_req_t req,
  // non-volatile backing store
  output med_pkg::med_nv_req_t     nv_write,
  // current values
  output logic [31:0]              pos_accel,
  output logic [31:0]              pos_decel,
  output logic [31:0]              spd_accel,
  output logic [31:0]              spd_decel
);
  import med_pkg::*;

  logic [31:0] value [4];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        value[i] <= ACCEL_RESET;
      end
    end else if (req.wr) begin
      value[req.sel] <= req.value;
    end
  end

  // forward every write to the persistent store
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      nv_write <= '0;
    end else begin
      nv_write <= req;
    end
  end

  assign pos_accel = value[0];
  assign pos_decel = value[1];
  assign spd_accel = value[2];
  assign spd_decel = value[3];
endmodule

// file: hdl/med_cmd_decoder.sv
module med_cmd_decoder (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // identity
  input  wire logic [7:0]           my_node_id,
  // request side
  input  wire logic                 req_valid,
  input  wire med_pkg::med_addr_t   req_addr,
  input  wire med_pkg::med_frame_t  req_frame,
  // encoder data
  input  wire logic signed [31:0]   raw_multiturn_position,
  input  wire logic signed [31:0]   zero_offset,
  // reply side and request ready
  output logic                      rsp_valid,
  input  wire logic                 rsp_ready,
  output med_pkg::med_addr_t        rsp_addr,
  output med_pkg::med_frame_t       rsp_frame,
  output logic                      req_ready,
  // acceleration values and store, refusal flag
  output med_pkg::med_nv_req_t      nv_write,
  output logic [31:0]               pos_accel,
  output logic [31:0]               pos_decel,
  output logic [31:0]               spd_accel,
  output logic [31:0]               spd_decel,
  output logic                      bad_cmd
);
  import med_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  logic        addr_ok;
  logic        tail_zero;
  logic        is_accel;
  logic        idx_ok;
  logic        is_rel;
  logic        is_raw;
  logic        take;
  med_nv_req_t store_req;
  logic [31:0] rel_pos;

  med_addr_check u_addr (
    .addr       (req_addr),
    .my_node_id (my_node_id),
    .match      (addr_ok)
  );

  assign req_ready = !rsp_valid;
  assign take      = req_valid && req_ready && addr_ok;
  assign tail_zero = (req_frame.data[7:1] == '0);
  assign is_accel  = req_frame.data[0] == CMD_ACCEL_WRITE;
  assign idx_ok    = req_frame.data[1] inside {IDX_POS_ACCEL, IDX_POS_DECEL, IDX_SPD_ACCEL,
                                               IDX_SPD_DECEL};
  assign is_rel    = (req_frame.data[0] == CMD_POS_REL) && tail_zero;
  assign is_raw    = (req_frame.data[0] == CMD_POS_RAW) && tail_zero;
  assign rel_pos   = 32'(raw_multiturn_position - zero_offset);

  always_comb begin
    store_req       = '0;
    store_req.wr    = take && is_accel && idx_ok;
    store_req.sel   = req_frame.data[1][1:0];
    store_req.value = med_le32(req_frame);
  end

  med_accel_store u_store (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .req       (store_req),
    .nv_write  (nv_write),
    .pos_accel (pos_accel),
    .pos_decel (pos_decel),
    .spd_accel (spd_accel),
    .spd_decel (spd_decel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // reply
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
    end else if (take && ((is_accel && idx_ok) || is_rel || is_raw)) begin
      rsp_valid <= 1'b1;
    end else if (rsp_ready) begin
      rsp_valid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rsp_frame <= '0;
    end else if (take) begin
      if (is_accel) begin
        rsp_frame <= req_frame;
      end else begin
        rsp_frame.data[0]   <= req_frame.data[0];
        rsp_frame.data[3:1] <= '0;
        for (int i = 0; i < 4; i++) begin
          rsp_frame.data[4+i] <= is_rel ? rel_pos[8*i +: 8]
                                        : raw_multiturn_position[8*i +: 8];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rsp_addr <= '0;
    end else if (take) begin
      rsp_addr.is_rs485 <= req_addr.is_rs485;
      rsp_addr.can_id   <= CAN_REPLY_ID;
      rsp_addr.node_id  <= my_node_id;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bad_cmd <= 1'b0;
    end else begin
      bad_cmd <= take && !((is_accel && idx_ok) || is_rel || is_raw);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_accel_echo: assert property (@(posedge ref_clk) disable iff (rst)
    (take && is_accel && idx_ok) |=> (rsp_valid && rsp_frame == $past(req_frame)))
    else $error("accel reply not an echo");

  chk_store_write: assert property (@(posedge ref_clk) disable iff (rst)
    (take && is_accel && req_frame.data[1] == IDX_SPD_DECEL) |=> ##1
      (spd_decel == $past(med_le32(req_frame), 2)))
    else $error("speed decel not stored");

  chk_nv_follow: assert property (@(posedge ref_clk) disable iff (rst)
    store_req.wr |=> (nv_write.wr && nv_write.value == $past(store_req.value)))
    else $error("store write not forwarded");

  chk_rel_value: assert property (@(posedge ref_clk) disable iff (rst)
    (take && is_rel) |=> (med_le32(rsp_frame) == $past(rel_pos)
      && rsp_frame.data[0] == CMD_POS_REL))
    else $error("relative position wrong");

  chk_raw_value: assert property (@(posedge ref_clk) disable iff (rst)
    (take && is_raw) |=> (med_le32(rsp_frame) == $past(raw_multiturn_position)
      && rsp_frame.data[3:1] == '0))
    else $error("raw position wrong");

  chk_pos_pad: assert property (@(posedge ref_clk) disable iff (rst)
    (take && is_rel) |=> (rsp_frame.data[3:1] == '0))
    else $error("position pad not zero");

  chk_reply_id: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(rsp_valid) |-> (rsp_addr.can_id == CAN_REPLY_ID))
    else $error("reply id wrong");

  chk_reply_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (rsp_valid && !rsp_ready) |=> (rsp_valid && $stable(rsp_frame)))
    else $error("reply dropped under stall");

  cov_accel:  cover property (@(posedge ref_clk) disable iff (rst) take && is_accel && idx_ok);
  cov_rel:    cover property (@(posedge ref_clk) disable iff (rst) take && is_rel);
  cov_raw:    cover property (@(posedge ref_clk) disable iff (rst) take && is_raw);
  chk_refuse_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    bad_cmd |-> !rsp_valid)
    else $error("refused request answered");

  chk_read_no_store: assert property (@(posedge ref_clk) disable iff (rst)
    (take && (is_rel || is_raw)) |=> !nv_write.wr)
    else $error("read request wrote store");

  cov_stall:  cover property (@(posedge ref_clk) disable iff (rst) (rsp_valid && !rsp_ready) [*2]);
  cov_refuse: cover property (@(posedge ref_clk) disable iff (rst) bad_cmd);
endmodule

// file: verif/med_host_model.sv
module med_host_model (
  // clock
  input  wire logic                ref_clk,
  // request side
  output logic                     req_valid,
  output med_pkg::med_addr_t       req_addr,
  output med_pkg::med_frame_t      req_frame,
  input  wire logic                req_ready,
  // reply side
  input  wire logic                rsp_valid,
  input  wire med_pkg::med_frame_t rsp_frame,
  output logic                     rsp_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  import med_pkg::*;
  initial begin
    req_valid = 1'b0;
    req_addr  = '0;
    req_frame = '0;
    rsp_ready = 1'b0;
  end
  ////////////////////////////////////////
  // request held to the taking edge, data scrambled after
  task automatic send(input med_addr_t a, input med_frame_t f, output bit ok);
    bit rdy;
    ok = 1'b0;
    @(negedge ref_clk);
    req_valid = 1'b1;
    req_addr  = a;
    req_frame = f;
    for (int i = 0; i < 20 && !ok; i++) begin
      rdy = req_ready;
      @(posedge ref_clk);
      ok = rdy;
      if (!ok) begin
        @(negedge ref_clk);
      end
    end
    @(negedge ref_clk);
    req_valid = 1'b0;
    req_frame = ~f;
  endtask
  ////////////////////////////////////////
  // reply accepted after a number of stall cycles
  task automatic recv(input int stall, output bit got, output med_frame_t r);
    bit v;
    got = 1'b0;
    r   = '0;
    for (int i = 0; i < 10 + stall && !got; i++) begin
      rsp_ready = (i >= stall);
      v = rsp_valid;
      r = rsp_frame;
      @(posedge ref_clk);
      got = v && rsp_ready;
      @(negedge ref_clk);
    end
    rsp_ready = 1'b0;
  endtask
endmodule

// file: verif/tb_motor_encoder_cmd_decoder.sv
module tb_motor_encoder_cmd_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  import med_pkg::*;
  logic               ref_clk = 1'b0;
  logic               rst = 1'b1;
  logic               req_valid, req_ready, rsp_valid, rsp_ready, bad_cmd;
  logic [7:0]         my_node_id = 8'h01;
  logic signed [31:0] raw_pos = 32'hf123_4567;
  logic signed [31:0] zero_off = 32'h0234_5678;
  med_addr_t          req_addr, rsp_addr;
  med_frame_t         req_frame, rsp_frame, r;
  med_nv_req_t        nv_write;
  logic [31:0]        pos_accel, pos_decel, spd_accel, spd_decel;
  int                 n_errors = 0;
  int                 num_checks = 0;
  bit                 got;
  localparam med_addr_t CAN_A = {1'b0, CAN_REQ_ID, 8'h00};
  med_cmd_decoder med_cmd_decoder_i (.ref_clk(ref_clk), .rst(rst), .my_node_id(my_node_id),
    .req_valid(req_valid), .req_addr(req_addr), .req_frame(req_frame),
    .raw_multiturn_position(raw_pos), .zero_offset(zero_off), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .rsp_addr(rsp_addr), .rsp_frame(rsp_frame), .req_ready(req_ready),
    .nv_write(nv_write), .pos_accel(pos_accel), .pos_decel(pos_decel), .spd_accel(spd_accel),
    .spd_decel(spd_decel), .bad_cmd(bad_cmd));
  med_host_model med_host_model_i (.ref_clk(ref_clk), .req_valid(req_valid), .req_addr(req_addr),
    .req_frame(req_frame), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_frame(rsp_frame),
    .rsp_ready(rsp_ready));
  ////////////////////////////////////////
  task automatic check(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      n_errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic req(input med_addr_t a, input med_frame_t f);
    bit ok;
    med_host_model_i.send(a, f, ok);
    if (!ok) begin
      check(1'b0, "request not taken");
      final_report();
    end
  endtask
  ////////////////////////////////////////
  task automatic t_accel();
    logic [127:0] exp_st;
    logic [31:0]  pl;
    med_frame_t   f;
    exp_st = '0;
    for (int i = 0; i < 4; i++) begin
      pl = {8'h80 | 8'(i), 24'h5a2710};
      f  = {pl, 16'h0000, 8'(i), CMD_ACCEL_WRITE};
      req(CAN_A, f);
      check(nv_write.wr === 1'b1 && nv_write.sel === 2'(i) && nv_write.value === pl, "store write");
      check(rsp_addr === {1'b0, CAN_REPLY_ID, 8'h01} && bad_cmd === 1'b0, "reply address");
      med_host_model_i.recv(i, got, r);
      check(got && r === f, "echo");
      @(negedge ref_clk);
      exp_st[i*32 +: 32] = pl;
      check({spd_decel, spd_accel, pos_decel, pos_accel} === exp_st, "stored values");
    end
  endtask
  task automatic t_read();
    logic [31:0] v;
    logic [7:0]  c;
    for (int k = 0; k < 2; k++) begin
      c = k ? CMD_POS_RAW : CMD_POS_REL;
      v = k ? raw_pos : raw_pos - zero_off;
      req(CAN_A, {56'h0, c});
      check(nv_write.wr === 1'b0 && bad_cmd === 1'b0, "read side effect");
      med_host_model_i.recv(0, got, r);
      check(got && r === {v, 24'h0, c}, "position reply");
    end
  endtask
  task automatic t_refuse();
    med_frame_t bad [5] = '{64'h0100_0000_0000_0060, 64'h0161, 64'h0443, 64'h0055, 64'h0060};
    for (int i = 0; i < 5; i++) begin
      req({1'b0, ((i == 4) ? 11'h140 : CAN_REQ_ID), 8'h00}, bad[i]);
      check(bad_cmd === (i < 4) && nv_write.wr === 1'b0, "refusal flag");
      med_host_model_i.recv(0, got, r);
      check(!got, "reply to refused request");
    end
  endtask
  task automatic t_rs485();
    req({1'b1, 11'h000, 8'h01}, {56'h0, CMD_POS_RAW});
    check(rsp_addr === {1'b1, CAN_REPLY_ID, 8'h01}, "rs485 reply address");
    med_host_model_i.recv(3, got, r);
    check(got && r === {raw_pos, 24'h0, CMD_POS_RAW}, "slow reply");
    req({1'b1, 11'h000, 8'h02}, {56'h0, CMD_POS_RAW});
    med_host_model_i.recv(0, got, r);
    check(!got, "other node answered");
  endtask
  ////////////////////////////////////////
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    t_accel();
    t_read();
    t_refuse();
    t_rs485();
    final_report();
  end
endmodule
